// ### core/irx_fifo.sv
`timescale 1ns/100ps
module irx_fifo #(
  parameter int unsigned W = 17,
  parameter int unsigned D = 4
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned PW = (D < 2) ? 1 : $clog2(D);

  if (D < 2) begin : g_chk
    $error("fifo depth below two");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
  } irx_fifo_st_t;

  irx_fifo_st_t q;
  irx_fifo_st_t d;
  logic         push;
  logic         pop;

  assign in_ready_o  = (q.cnt != (PW+1)'(D));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == (PW)'(D - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == (PW)'(D - 1)) ? '0 : q.rp + 1'b1;
    end
    if (push & ~pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop & ~push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : irx_fifo

// ### core/irx_ram.sv
`timescale 1ns/100ps
module irx_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] wa_i,
  input  wire logic [DW-1:0] wd_i,
  input  wire logic [AW-1:0] ra_i,
  output logic      [DW-1:0] rd_o
);
  logic [DW-1:0] mem [2**AW];

  // no reset: contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
    rd_o <= mem[ra_i];
  end
endmodule : irx_ram

// ### core/irx_rx_port.sv
`timescale 1ns/100ps
// Behaviour
// - role bit 1 drives clocks as master, 0 takes them; resets master
// - format field: 0 standard, 1 right, 2 left justified; resets left
// - word length field: 16, 20, 24 or 32 bits per channel
// - channel swap bit makes right channel come first in a frame
// - frame polarity bit inverts the meaning of the left-right clock
// - bit clock polarity bit inverts the bit clock and data edge
// - master clock is system clock over twice divisor; zero stops it
// - bit clock is master over divisor, or twice it when system divisor is above 1; zero stops
// - frame clock is bit clock over twice frame divisor; zero stops it
// - slave with clock share takes clocks from the transmit port
// - master clock idle level: polarity 0 holds 1, polarity 1 holds 0
// - frame clock changes on falling bit edge at 0, rising at 1
// - samples go to the buffer as 16-bit units at 1, bytes at 0
// - received data forwarded only while push enable is set
// - channel mode: zeros, right only, left only, or both channels
// - received data stored in a 256-byte buffer mapped on the bus
// - second 256-byte mapped buffer is sent out over the serial link
module irx_rx_port #(
  parameter int unsigned FIFO_DEPTH = irx_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mclk_o,
  input  wire logic        bclk_i,
  output logic             bclk_o,
  output logic             bclk_oe_o,
  input  wire logic        lrck_i,
  output logic             lrck_o,
  output logic             lrck_oe_o,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  input  wire logic        tx_bclk_i,
  input  wire logic        tx_lrck_i
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("fifo depth below two");
  end

  typedef struct packed {
    irx_pkg::irx_bus_st_t st;
    logic                 ack;
    logic [31:0]          dat;
    logic [7:0]           ctrl;
    logic [7:0]           sdiv;
    logic [7:0]           mdiv;
    logic [7:0]           bdiv;
    logic [7:0]           mode;
    logic [7:0]           mcnt;
    logic                 mclk;
    logic [8:0]           bcnt;
    logic                 bclk;
    logic [7:0]           lcnt;
    logic                 lrck;
    logic [1:0]           sy_b;
    logic [1:0]           sy_l;
    logic [1:0]           sy_d;
    logic                 pb;
    logic                 pl;
    logic [5:0]           cnt;
    logic [31:0]          sh;
    logic                 left;
    logic                 pv;
    logic [16:0]          pd;
    logic [7:0]           wptr;
    logic                 hi;
    logic [7:0]           hbyte;
    logic [7:0]           optr;
    logic [7:0]           osh;
    logic [2:0]           obit;
    logic                 sdo;
  } irx_core_st_t;

  irx_core_st_t q;
  irx_core_st_t d;

  logic        en;
  logic        master;
  logic        share;
  logic        run_m;
  logic        run_b;
  logic        mtick;
  logic        btick;
  logic        fedge;
  logic        ltick;
  logic [8:0]  blim;
  logic        eb;
  logic        el;
  logic        sedge;
  logic        cedge;
  logic        ch;
  logic        left_n;
  logic [1:0]  fmt;
  logic [1:0]  chm;
  logic [5:0]  wl;
  logic [5:0]  skip;
  logic [5:0]  ncnt;
  logic        inw;
  logic [31:0] word;
  logic [31:0] w16;
  logic [31:0] w8;
  logic [15:0] unit;
  logic        keep;
  logic        f_in_rdy;
  logic        f_out_vld;
  logic        f_out_rdy;
  logic [16:0] f_out;
  logic        rxw;
  logic [7:0]  rxwd;
  logic [7:0]  rx_rd;
  logic [7:0]  tx_rd;
  logic        txw;
  logic [13:0] idx;
  logic [7:0]  rdv;
  logic        wr;

  ////////////////////////////////////////////////////////////////////////////
  assign en        = q.mode[irx_pkg::M_EN];
  assign master    = q.ctrl[irx_pkg::C_ROLE];
  assign share     = q.mode[irx_pkg::M_SHARE];
  assign fmt       = q.ctrl[irx_pkg::C_FMT +: 2];
  assign chm       = q.mode[irx_pkg::M_CHM +: 2];
  assign wb_dat_o  = q.dat;
  assign wb_ack_o  = q.ack;
  assign mclk_o    = q.mclk;
  assign bclk_o    = q.bclk;
  assign lrck_o    = q.lrck;
  assign bclk_oe_o = q.ctrl[irx_pkg::C_ROLE];
  assign lrck_oe_o = q.ctrl[irx_pkg::C_ROLE];
  assign sdo_o     = q.sdo;

  // clock generation: master counter in system cycles, bit counter in master ticks, frame counter in frame edges
  assign run_m = en & master & (q.sdiv != 8'h00);
  assign mtick = run_m & (q.mcnt >= q.sdiv - 8'h01);
  assign blim  = (q.sdiv == 8'h01) ? {1'h0, q.mdiv} : {q.mdiv, 1'h0};
  assign run_b = run_m & (q.mdiv != 8'h00);
  // >= so that a divisor lowered mid-count ends the period instead of wrapping
  assign btick = run_b & mtick & (q.bcnt >= blim - 9'h001);
  // frame edge is the bit clock pin edge chosen by the frame-edge bit
  assign fedge = btick & ((~q.bclk) == q.mode[irx_pkg::M_FRAME_CHANGE_EDGE]);
  assign ltick = fedge & (q.lcnt >= q.bdiv - 8'h01);

  // effective serial clocks; shared ones are already in this domain
  assign eb = master ? q.bclk : (share ? tx_bclk_i : q.sy_b[1]);
  assign el = master ? q.lrck : (share ? tx_lrck_i : q.sy_l[1]);
  assign sedge = en & (eb != q.pb) & (eb == ~q.ctrl[irx_pkg::C_BCP]);
  assign cedge = en & (eb != q.pb) & (eb == q.ctrl[irx_pkg::C_BCP]);
  assign ch    = (el != q.pl);
  assign left_n = el ^ (fmt == irx_pkg::FMT_I2S) ^ q.ctrl[irx_pkg::C_FPOL]
                  ^ q.ctrl[irx_pkg::C_SWAP];

  // capture window per channel; standard format skips the first slot
  assign wl   = irx_pkg::irx_wl_bits(q.ctrl[irx_pkg::C_WL +: 2]);
  assign skip = {5'h00, (fmt == irx_pkg::FMT_I2S)};
  assign ncnt = ch ? 6'h00 : q.cnt;
  assign inw  = (fmt == irx_pkg::FMT_RJ) | ((ncnt >= skip) & (ncnt < wl + skip));
  assign word = (wl == 6'h20) ? q.sh : (q.sh & ((32'h00000001 << wl) - 32'h00000001));
  assign w16  = word >> (wl - 6'h10);
  assign w8   = word >> (wl - 6'h08);
  assign unit = q.mode[irx_pkg::M_B16] ? w16[15:0] : {8'h00, w8[7:0]};
  assign keep = (chm == irx_pkg::CHM_BOTH)
              | ((chm == irx_pkg::CHM_LEFT) & q.left)
              | ((chm == irx_pkg::CHM_RIGHT) & ~q.left);

  // drain: a 16-bit unit takes two cycles, low byte first, which stalls the fifo
  assign f_out_rdy = ~q.hi;
  assign rxw       = q.hi | f_out_vld;
  assign rxwd      = q.hi ? q.hbyte : f_out[7:0];

  // register bus decode
  assign idx = wb_adr_i[15:2];
  assign wr  = (q.st == irx_pkg::BUS_BUSY) & wb_we_i & wb_sel_i[0];
  assign txw = wr & (idx[13:8] == irx_pkg::IDX_TXBUF);
  assign rdv = (idx == irx_pkg::IDX_CTRL) ? q.ctrl :
               (idx == irx_pkg::IDX_SDIV) ? q.sdiv :
               (idx == irx_pkg::IDX_MDIV) ? q.mdiv :
               (idx == irx_pkg::IDX_BDIV) ? q.bdiv :
               (idx == irx_pkg::IDX_MODE) ? q.mode :
               (idx == irx_pkg::IDX_STAT) ? q.wptr :
               (idx[13:8] == irx_pkg::IDX_RXBUF) ? rx_rd : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d      = q;
    d.sy_b = {q.sy_b[0], bclk_i};
    d.sy_l = {q.sy_l[0], lrck_i};
    d.sy_d = {q.sy_d[0], sdi_i};
    d.pb   = eb;
    // a pending unit waits for fifo room; a newer one replaces it
    d.pv   = q.pv & ~f_in_rdy;

    if (run_m) begin
      d.mcnt = mtick ? 8'h00 : q.mcnt + 8'h01;
      if (mtick) begin
        d.mclk = ~q.mclk;
      end
    end else begin
      d.mcnt = 8'h00;
      d.mclk = ~q.mode[irx_pkg::M_MASTER_CLOCK_IDLE_LEVEL];
    end

    if (run_b) begin
      if (mtick) begin
        d.bcnt = btick ? 9'h000 : q.bcnt + 9'h001;
      end
      if (btick) begin
        d.bclk = ~q.bclk;
      end
    end else begin
      d.bcnt = 9'h000;
      d.bclk = q.ctrl[irx_pkg::C_BCP];
    end

    if (run_b & (q.bdiv != 8'h00)) begin
      if (fedge) begin
        d.lcnt = ltick ? 8'h00 : q.lcnt + 8'h01;
      end
      if (ltick) begin
        d.lrck = ~q.lrck;
      end
    end else begin
      d.lcnt = 8'h00;
      d.lrck = 1'h0;
    end

    if (sedge) begin
      d.pl  = el;
      d.cnt = (ncnt == 6'h3F) ? ncnt : ncnt + 6'h01;
      if (inw) begin
        d.sh = ch ? {31'h00000000, q.sy_d[1]} : {q.sh[30:0], q.sy_d[1]};
      end else if (ch) begin
        d.sh = 32'h00000000;
      end
      if (ch) begin
        d.left = left_n;
        d.pv   = q.mode[irx_pkg::M_PUSH];
        d.pd   = {q.mode[irx_pkg::M_B16], keep ? unit : 16'h0000};
      end
    end

    if (q.hi) begin
      d.hi = 1'h0;
    end else if (f_out_vld) begin
      d.hi    = f_out[16];
      d.hbyte = f_out[15:8];
    end
    if (rxw) begin
      d.wptr = q.wptr + 8'h01;
    end

    // outgoing bytes, msb first, one bit per data-change edge
    if (cedge) begin
      d.sdo  = (q.obit == 3'h0) ? tx_rd[7] : q.osh[7];
      d.osh  = (q.obit == 3'h0) ? {tx_rd[6:0], 1'h0} : {q.osh[6:0], 1'h0};
      d.obit = q.obit + 3'h1;
      if (q.obit == 3'h0) begin
        d.optr = q.optr + 8'h01;
      end
    end

    unique case (q.st)
      irx_pkg::BUS_IDLE: begin
        if (wb_cyc_i & wb_stb_i) begin
          d.st = irx_pkg::BUS_BUSY;
        end
      end
      irx_pkg::BUS_BUSY: begin
        d.st  = irx_pkg::BUS_ACK;
        d.ack = 1'h1;
        d.dat = {24'h000000, rdv};
        if (wr) begin
          if (idx == irx_pkg::IDX_CTRL) d.ctrl = wb_dat_i[7:0];
          if (idx == irx_pkg::IDX_SDIV) d.sdiv = wb_dat_i[7:0];
          if (idx == irx_pkg::IDX_MDIV) d.mdiv = wb_dat_i[7:0];
          if (idx == irx_pkg::IDX_BDIV) d.bdiv = wb_dat_i[7:0];
          if (idx == irx_pkg::IDX_MODE) d.mode = wb_dat_i[7:0];
        end
      end
      irx_pkg::BUS_ACK: begin
        d.st  = irx_pkg::BUS_IDLE;
        d.ack = 1'h0;
      end
      default: begin
        d.st  = irx_pkg::BUS_IDLE;
        d.ack = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q      <= '0;
      q.ctrl <= irx_pkg::CTRL_RST;
      q.mode <= irx_pkg::MODE_RST;
      q.sdiv <= irx_pkg::DIV_RST;
      q.mdiv <= irx_pkg::DIV_RST;
      q.bdiv <= irx_pkg::DIV_RST;
      q.mclk <= irx_pkg::MCLK_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  irx_fifo #(
    .W (irx_pkg::FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (q.pv),
    .in_data_i   (q.pd),
    .in_ready_o  (f_in_rdy),
    .out_valid_o (f_out_vld),
    .out_data_o  (f_out),
    .out_ready_i (f_out_rdy)
  );

  irx_ram #(.AW(irx_pkg::BUF_AW), .DW(8)) u_rxbuf (
    .clk_i (clk_i),
    .we_i  (rxw),
    .wa_i  (q.wptr),
    .wd_i  (rxwd),
    .ra_i  (idx[7:0]),
    .rd_o  (rx_rd)
  );

  irx_ram #(.AW(irx_pkg::BUF_AW), .DW(8)) u_txbuf (
    .clk_i (clk_i),
    .we_i  (txw),
    .wa_i  (idx[7:0]),
    .wd_i  (wb_dat_i[7:0]),
    .ra_i  (q.optr),
    .rd_o  (tx_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_take16;
    f_out_vld && f_out_rdy && f_out[16];
  endsequence
  sequence s_hi_byte;
    rxw && q.hi;
  endsequence

  property p_bus;
    (q.st == irx_pkg::BUS_IDLE) && wb_cyc_i && wb_stb_i |-> ##2 wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not two cycles");
  property p_role;
    !master && !share |-> eb == $past(bclk_i, 2);
  endproperty
  a_role: assert property (p_role) else $error("slave bit clock not from pin");
  property p_share;
    !master && share |-> (eb == tx_bclk_i) && (el == tx_lrck_i);
  endproperty
  a_share: assert property (p_share) else $error("shared clocks not used");
  property p_label;
    sedge && ch |=> q.left == ($past(el) ^ ($past(fmt) == irx_pkg::FMT_I2S)
                   ^ $past(q.ctrl[irx_pkg::C_FPOL]) ^ $past(q.ctrl[irx_pkg::C_SWAP]));
  endproperty
  a_label: assert property (p_label) else $error("channel label wrong");
  property p_mclk;
    mtick |=> mclk_o != $past(mclk_o);
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock did not toggle");
  property p_midle;
    !run_m |=> mclk_o == !$past(q.mode[irx_pkg::M_MASTER_CLOCK_IDLE_LEVEL]);
  endproperty
  a_midle: assert property (p_midle) else $error("master clock idle level");
  property p_bstop;
    !run_b |=> bclk_o == $past(q.ctrl[irx_pkg::C_BCP]);
  endproperty
  a_bstop: assert property (p_bstop) else $error("bit clock not idle");
  property p_fedge;
    $past(ltick) |-> $changed(lrck_o) && (bclk_o == $past(q.mode[irx_pkg::M_FRAME_CHANGE_EDGE]));
  endproperty
  a_fedge: assert property (p_fedge) else $error("frame clock on wrong edge");
  property p_push;
    sedge && ch && !q.mode[irx_pkg::M_PUSH] && !q.pv |=> !q.pv;
  endproperty
  a_push: assert property (p_push) else $error("data forwarded with push off");
  property p_zero;
    sedge && ch && (chm == irx_pkg::CHM_ZERO) |=> q.pd[15:0] == 16'h0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zeros mode passed data");
  property p_pair;
    s_take16 |=> s_hi_byte ##1 !q.hi;
  endproperty
  a_pair: assert property (p_pair) else $error("16-bit unit not split");
  property p_wptr;
    rxw |=> q.wptr == $past(q.wptr) + 8'h01;
  endproperty
  a_wptr: assert property (p_wptr) else $error("buffer pointer not advanced");
  property p_en;
    !en && !q.pv |=> !q.pv;
  endproperty
  a_en: assert property (p_en) else $error("disabled port forwarded data");
endmodule : irx_rx_port

// ### shared/irx_pkg.sv
package irx_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [13:0] IDX_CTRL   = 14'h2538;
  localparam logic [13:0] IDX_SDIV   = 14'h253A;
  localparam logic [13:0] IDX_MDIV   = 14'h253B;
  localparam logic [13:0] IDX_BDIV   = 14'h253C;
  localparam logic [13:0] IDX_MODE   = 14'h253D;
  localparam logic [13:0] IDX_STAT   = 14'h253E;
  localparam logic [5:0]  IDX_RXBUF  = 6'h28;
  localparam logic [5:0]  IDX_TXBUF  = 6'h29;

  localparam logic [7:0]  CTRL_RST   = 8'hC0;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  DIV_RST    = 8'h00;
  localparam logic        MCLK_RST   = 1'h1;

  // interface control fields
  localparam int unsigned C_ROLE     = 7;
  localparam int unsigned C_FMT      = 5;
  localparam int unsigned C_WL       = 3;
  localparam int unsigned C_SWAP     = 2;
  localparam int unsigned C_FPOL     = 1;
  localparam int unsigned C_BCP      = 0;
  // transfer mode fields
  localparam int unsigned M_SHARE    = 7;
  localparam int unsigned M_MASTER_CLOCK_IDLE_LEVEL     = 6;
  localparam int unsigned M_FRAME_CHANGE_EDGE     = 5;
  localparam int unsigned M_B16      = 4;
  localparam int unsigned M_PUSH     = 3;
  localparam int unsigned M_CHM      = 1;
  localparam int unsigned M_EN       = 0;

  localparam logic [1:0]  FMT_I2S    = 2'h0;
  localparam logic [1:0]  FMT_RJ     = 2'h1;
  localparam logic [1:0]  FMT_LJ     = 2'h2;
  localparam logic [1:0]  CHM_ZERO   = 2'h0;
  localparam logic [1:0]  CHM_RIGHT  = 2'h1;
  localparam logic [1:0]  CHM_LEFT   = 2'h2;
  localparam logic [1:0]  CHM_BOTH   = 2'h3;

  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W     = 17;
  localparam int unsigned BUF_AW     = 8;

  typedef enum logic [1:0] {BUS_IDLE, BUS_BUSY, BUS_ACK} irx_bus_st_t;

  function automatic logic [5:0] irx_wl_bits(input logic [1:0] code);
    unique case (code)
      2'h0: irx_wl_bits = 6'h10;
      2'h1: irx_wl_bits = 6'h14;
      2'h2: irx_wl_bits = 6'h18;
      2'h3: irx_wl_bits = 6'h20;
    endcase
  endfunction : irx_wl_bits
endpackage : irx_pkg

// ### sim/irx_codec_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module irx_codec_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        act_i,
  input  wire logic        lag_i,
  input  wire logic        bclk_i,
  input  wire logic        lrck_i,
  input  wire logic [31:0] hi_word_i,
  input  wire logic [31:0] lo_word_i,
  output logic             sdi_o
);
  logic        b1_q, b2_q, lf_q, bit_q, dly_q;
  logic [31:0] sh_q;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {b1_q, b2_q, lf_q, bit_q, dly_q, sdi_o} <= '0;
      sh_q <= '0;
    end else begin
      b1_q  <= bclk_i;
      b2_q  <= b1_q;
      dly_q <= bit_q;
      // fall seen one cycle late: a frame clock moved a cycle after it is not missed
      if (b2_q && !b1_q) begin
        lf_q <= lrck_i;
        // always 32 bits a channel, enough for every word length
        if (lrck_i != lf_q) begin
          bit_q <= lrck_i ? hi_word_i[31] : lo_word_i[31];
          sh_q  <= (lrck_i ? hi_word_i : lo_word_i) << 1;
        end else begin
          bit_q <= sh_q[31];
          sh_q  <= sh_q << 1;
        end
      end
      // released line has no pull, so it keeps changing
      sdi_o <= !act_i ? !sdi_o : (lag_i ? dly_q : bit_q);
    end
  end
endmodule : irx_codec_model

// ### sim/irx_rx_port_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got 0x%0h exp 0x%0h", $time, g, e); end end
////////////////////////////////////////////////////////////
module irx_rx_port_tb;
  localparam logic [13:0] RI [5] = '{irx_pkg::IDX_CTRL, irx_pkg::IDX_SDIV, irx_pkg::IDX_MDIV,
                                     irx_pkg::IDX_BDIV, irx_pkg::IDX_MODE};
  localparam logic [7:0]  RV [5] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};
  // role share fmt wl chm fpol swap b16 0
  localparam logic [11:0] CS [8] = '{12'hA32, 12'h862, 12'h998, 12'h9E6,
                                     12'hA02, 12'h232, 12'h4A0, 12'hBBC};
  logic        clk_i, arst_n_i, cyc, stb, we, ack, mclk, bco, bcoe, lro, lroe, sdi;
  logic        jnk, act, lag, bc, bp, sdo;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [7:0]  v;
  logic [31:0] dat, rdat, rd, rng, hi_w, lo_w;
  logic [9:0]  cnt = '0;
  int          fails = 0;
  int          check_count = 0;
  int          p, q, sd, md, bd;
  wire         bct = bcoe ? bco : cnt[3];
  wire         lrt = lroe ? lro : cnt[9];
  ////////////////////////////////////////////////////////////
  irx_rx_port i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .mclk_o(mclk), .bclk_i(bcoe ? bco : (jnk ? cnt[1] : cnt[3])),
    .bclk_o(bco), .bclk_oe_o(bcoe), .lrck_i(lroe ? lro : (jnk ? cnt[6] : cnt[9])),
    .lrck_o(lro), .lrck_oe_o(lroe), .sdi_i(sdi), .sdo_o(sdo), .tx_bclk_i(cnt[3]),
    .tx_lrck_i(cnt[9]));
  irx_codec_model i_adc (.clk_i(clk_i), .arst_n_i(arst_n_i), .act_i(act), .lag_i(lag),
    .bclk_i(bct), .lrck_i(lrt), .hi_word_i(hi_w), .lo_word_i(lo_w), .sdi_o(sdi));
  ////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cnt <= cnt + 10'h001;
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  function automatic logic pin(input int w);
    return (w == 0) ? mclk : ((w == 1) ? bco : lro);
  endfunction : pin
  function automatic logic [15:0] eu(input logic [11:0] c, input logic [31:0] w, input logic h);
    int          n;
    logic [15:0] u;
    n = (c[7:6] == 2'h3) ? 32 : 16 + 4 * c[7:6];
    u = (c[9:8] == 2'h0) ? w[30 -: 16] : ((c[9:8] == 2'h1) ? w[n-1 -: 16] : w[31 -: 16]);
    if (!((h ^ (c[9:8] == 2'h0) ^ c[3] ^ c[2]) ? c[5] : c[4])) return 16'h0000;
    return c[1] ? u : {8'h00, u[15:8]};
  endfunction : eu
  task automatic wb(input logic w, input logic [13:0] i, input logic [7:0] d, input logic s);
    int          n;
    logic [31:0] r;
    r = xs();
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, r[1:0]};
    dat <= {r[31:8], d};
    sel <= {r[3:1], s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic per(input int w, output int t);
    int   n, r;
    logic a, b;
    r = 0;
    t = 0;
    a = pin(w);
    for (n = 0; n < 3000 && r < 2; n++) begin
      @(posedge clk_i);
      b = pin(w);
      if (b && !a) begin
        r++;
        t = (r == 1) ? n : n - t;
        bc = bco;
      end
      a = b;
    end
    if (r < 2) t = -1;
  endtask : per
  task automatic still(input int w, input int n);
    int   ch;
    logic a;
    ch = 0;
    a = pin(w);
    repeat (n) begin
      @(posedge clk_i);
      if (pin(w) !== a) ch++;
    end
    `CHK(ch, 0)
  endtask : still
  task automatic run(input logic [11:0] c);
    logic [7:0]  p0, pe;
    logic [7:0]  b [4];
    logic [15:0] w0, w1, e0, e1;
    int          u;
    hi_w = xs();
    lo_w = xs();
    lag <= rng[0];
    jnk <= c[10];
    wb(1'b1, irx_pkg::IDX_SDIV, 8'h01, 1'b1);
    wb(1'b1, irx_pkg::IDX_MDIV, 8'h08, 1'b1);
    wb(1'b1, irx_pkg::IDX_BDIV, 8'h20, 1'b1);
    wb(1'b1, irx_pkg::IDX_CTRL, {c[11], c[9:8], c[7:6], c[2], c[3], 1'b0}, 1'b1);
    wb(1'b0, irx_pkg::IDX_STAT, 8'h00, 1'b1);
    p0 = rd[7:0];
    wb(1'b1, irx_pkg::IDX_MODE, {c[10], 2'b00, c[1], 1'b1, c[5:4], 1'b1}, 1'b1);
    act <= 1'b1;
    repeat (3200) @(posedge clk_i);
    wb(1'b1, irx_pkg::IDX_MODE, {c[10], 2'b00, c[1], 1'b0, c[5:4], 1'b1}, 1'b1);
    repeat (20) @(posedge clk_i);
    wb(1'b0, irx_pkg::IDX_STAT, 8'h00, 1'b1);
    pe = rd[7:0];
    `CHK(pe != p0, 1'b1)
    repeat (1100) @(posedge clk_i);
    wb(1'b0, irx_pkg::IDX_STAT, 8'h00, 1'b1);
    `CHK(rd[7:0], pe)
    u = c[1] ? 2 : 1;
    for (int k = 0; k < 2 * u; k++) begin
      wb(1'b0, {irx_pkg::IDX_RXBUF, 8'(pe - 2 * u + k)}, 8'h00, 1'b1);
      b[k] = rd[7:0];
    end
    w0 = c[1] ? {b[1], b[0]} : {8'h00, b[0]};
    w1 = c[1] ? {b[3], b[2]} : {8'h00, b[1]};
    e0 = eu(c, hi_w, 1'b1);
    e1 = eu(c, lo_w, 1'b0);
    `CHK((w0 === e0 && w1 === e1) || (w0 === e1 && w1 === e0), 1'b1)
    wb(1'b1, irx_pkg::IDX_MODE, 8'h00, 1'b1);
    act <= 1'b0;
  endtask : run
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    rng = 32'd49608;
    {cyc, stb, we, jnk, act, lag, arst_n_i} = '0;
    {adr, sel, dat, hi_w, lo_w} = '0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    `CHK(bcoe, 1'b1)
    `CHK(mclk, 1'b1)
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, RI[i], 8'h00, 1'b1);
      `CHK(rd, {24'h0, RV[i]})
    end
    wb(1'b0, 14'h2539, 8'h00, 1'b1);
    `CHK(rd, 32'h0)
    for (int i = 1; i < 4; i++) begin
      v = 8'(xs()) | 8'h01;
      wb(1'b1, RI[i], v, 1'b1);
      wb(1'b1, RI[i], ~v, 1'b0);
      wb(1'b0, RI[i], 8'h00, 1'b1);
      `CHK(rd, {24'h0, v})
    end
    still(0, 100);
    wb(1'b1, irx_pkg::IDX_CTRL, 8'h40, 1'b1);
    repeat (3) @(posedge clk_i);
    `CHK({bcoe, lroe}, 2'b00)
    wb(1'b1, irx_pkg::IDX_CTRL, 8'hC1, 1'b1);
    wb(1'b1, irx_pkg::IDX_MODE, 8'h40, 1'b1);
    repeat (10) @(posedge clk_i);
    `CHK(mclk, 1'b0)
    `CHK(bco, 1'b1)
    wb(1'b1, irx_pkg::IDX_SDIV, 8'h00, 1'b1);
    wb(1'b1, irx_pkg::IDX_MODE, 8'h41, 1'b1);
    still(0, 100);
    wb(1'b1, irx_pkg::IDX_SDIV, 8'h02, 1'b1);
    wb(1'b1, irx_pkg::IDX_MDIV, 8'h00, 1'b1);
    still(1, 200);
    wb(1'b1, irx_pkg::IDX_MDIV, 8'h02, 1'b1);
    wb(1'b1, irx_pkg::IDX_BDIV, 8'h00, 1'b1);
    still(2, 400);
    wb(1'b1, irx_pkg::IDX_CTRL, 8'hC0, 1'b1);
    for (sd = 1; sd < 5; sd++) begin
      md = 2 + xs() % 2;
      bd = 1 + xs() % 3;
      bp = rng[5];
      wb(1'b1, irx_pkg::IDX_SDIV, 8'(sd), 1'b1);
      wb(1'b1, irx_pkg::IDX_MDIV, 8'(md), 1'b1);
      wb(1'b1, irx_pkg::IDX_BDIV, 8'(bd), 1'b1);
      wb(1'b1, irx_pkg::IDX_MODE, {2'b00, bp, 5'h01}, 1'b1);
      q = 2 * sd;
      for (int w = 0; w < 3; w++) begin
        per(w, p);
        per(w, p);
        `CHK(p, q)
        q = q * ((w == 0) ? ((sd == 1) ? md : 2 * md) : 2 * bd);
      end
      `CHK(bc, bp)
    end
    // whole outgoing buffer set, so whichever byte is shifting out is all ones
    for (int k = 0; k < 256; k++) wb(1'b1, {irx_pkg::IDX_TXBUF, 8'(k)}, 8'hFF, 1'b1);
    repeat (500) @(posedge clk_i);
    `CHK(sdo, 1'b1)
    for (int i = 0; i < 8; i++) run(CS[i]);
    print_verdict();
  end
  // bound from the longest expected run with margin
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
endmodule : irx_rx_port_tb
